//--- testbench/psc_capture_model.sv
// Capture logic model that latches sample words on the rising edge of the sample strobe.
`timescale 1ns/1ps
`include "psc_map.svh"

module psc_capture_model (
   // Converter outputs seen by the capture logic.
   input wire logic sample_strobe,
   input wire logic [`PSC_WORD_W-1:0] sample_word_bits,
   input wire logic range_exceeded_flag,
   input wire logic word_valid,
   // Last accepted word and a running count of accepted words.
   output logic [`PSC_WORD_W-1:0] cap_word,
   output logic cap_flag,
   output int cap_cnt
);
   // ---------------------------------------------------------------------------
   // Capture
   // ---------------------------------------------------------------------------
   // Start with nothing captured.
   initial begin
      cap_word = '0;
      cap_flag = 1'b0;
      cap_cnt = 0;
   end

   // Latching on the strobe rather than a local clock keeps the word centred in its window.
   // Words from a pipeline that has not refilled since wake-up are stale and are dropped.
   // strobe capture, stale discard
   always @(posedge sample_strobe) begin
      if (word_valid === 1'b1) begin
         cap_word <= sample_word_bits;
         cap_flag <= range_exceeded_flag;
         cap_cnt <= cap_cnt + 1;
      end
   end
endmodule // psc_capture_model

//--- testbench/tb_pipelined_adc_sample_output.sv
// Self-checking bench for the pipelined sample output block.
`timescale 1ns/1ps
`include "psc_map.svh"

module tb_pipelined_adc_sample_output;
   import psc_pkg::*;

   // ---------------------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------------------
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   psc_addr_t paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic conv_clk = 1'b0;
   logic signed [13:0] analog_level = 14'sh0000;
   logic [1:0] clock_and_format_select = 2'h0;
   logic [1:0] power_state_select = `PSC_PSS_ON;
   logic [11:0] sample_word_bits;
   logic range_exceeded_flag;
   logic sample_strobe;
   logic diff_clock_mode;
   logic word_valid;
   logic irq;
   logic [11:0] cap_word;
   logic cap_flag;
   int cap_cnt;
   int err_count = 0;
   int cmp_count = 0;
   int seed = 75005;
   int cyc = 0;
   int hist[$];
   int v;
   int n0;
   bit chk_en = 1'b0;
   logic [31:0] rd;
   logic er;
   logic [2:0] acc;

   psc_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_clk(conv_clk),
      .analog_level(analog_level), .clock_and_format_select(clock_and_format_select),
      .power_state_select(power_state_select), .sample_word_bits(sample_word_bits),
      .range_exceeded_flag(range_exceeded_flag), .sample_strobe(sample_strobe),
      .diff_clock_mode(diff_clock_mode), .word_valid(word_valid), .irq(irq));

   psc_capture_model cap (.sample_strobe(sample_strobe), .sample_word_bits(sample_word_bits),
      .range_exceeded_flag(range_exceeded_flag), .word_valid(word_valid),
      .cap_word(cap_word), .cap_flag(cap_flag), .cap_cnt(cap_cnt));

   // ---------------------------------------------------------------------------
   // Clocks and analog source
   // ---------------------------------------------------------------------------
   // System clock, 4 ns period.
   always #2 pclk = ~pclk;

   // Conversion clock at 6.25 MSPS with a phase unrelated to the system clock.
   // rate within limits
   initial begin
      #53.3;
      forever begin
         #80 conv_clk = ~conv_clk;
      end
   end

   // A new level is tracked from each rise and is stable across the next fall.
   // track then hold
   always @(posedge conv_clk) begin
      analog_level <= 14'($random(seed) % 2600);
   end

   // Model of the held samples, one entry per conversion clock fall.
   always @(negedge conv_clk) begin
      hist.push_back(int'(analog_level));
   end

   // ---------------------------------------------------------------------------
   // Model, compare and report
   // ---------------------------------------------------------------------------
   // Offset binary of the clipped level, top bit inverted for two's complement.
   function automatic logic [11:0] enc(input int x, input bit twos);
      int c;
      c = (x > 2047) ? 2047 : ((x < -2048) ? -2048 : x);
      enc = 12'(c + 2048) ^ (twos ? 12'h800 : 12'h000);
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      if (err_count == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Every captured word is the sample held seven falls before its strobe.
   // latency, coding, range flag
   always @(cap_cnt) begin
      if (chk_en && hist.size() >= 8) begin
         v = hist[hist.size() - 8];
         chk(32'(cap_word), 32'(enc(v, clock_and_format_select[0])));
         chk(32'(cap_flag), 32'(v > 2047 || v < -2048));
      end
   end

   // A hang is cut short well beyond the expected run length.
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 30000) begin
         err_count++;
         stop_test();
      end
   end

   // ---------------------------------------------------------------------------
   // Register bus
   // ---------------------------------------------------------------------------
   // One APB transfer; the request stands until pready is seen high.
   task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the bench timeout ends a wait for the answer.
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd & m, e);
   endtask

   // ---------------------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------------------
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values and an unmapped address.
      rdchk(`PSC_OFF_CTRL, 32'hFFFFFFFF, 32'h0);
      rdchk(`PSC_OFF_INT_STAT, 32'hFFFFFFFF, 32'h0);
      rdchk(`PSC_OFF_INT_MASK, 32'hFFFFFFFF, 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      chk(32'(er), 32'h1);
      // Every select code, with a settling gap while the new select level passes the input synchroniser.
      // select decode
      for (int f = 0; f < 4; f++) begin
         chk_en = 1'b0;
         @(posedge pclk);
         clock_and_format_select <= 2'(f);
         repeat (9) @(negedge conv_clk);
         chk(32'(diff_clock_mode), 32'(f[1]));
         rdchk(`PSC_OFF_STATUS, 32'h1F, 32'({1'b1, f[0], f[1], 2'b00}));
         chk_en = 1'b1;
         n0 = cap_cnt;
         repeat (20) @(negedge conv_clk);
         chk(32'(cap_cnt - n0 > 18), 32'h1);
      end
      chk_en = 1'b0;
      // Range and refill events are sticky; refill drives the interrupt once unmasked.
      rdchk(`PSC_OFF_INT_STAT, 32'h7, 32'h5);
      apb(1'b1, `PSC_OFF_INT_MASK, 32'h4);
      repeat (2) @(posedge pclk);
      chk(32'(irq), 32'h1);
      apb(1'b1, `PSC_OFF_INT_STAT, 32'h4);
      repeat (2) @(posedge pclk);
      chk(32'(irq), 32'h0);
      rdchk(`PSC_OFF_INT_STAT, 32'h4, 32'h0);
      apb(1'b1, `PSC_OFF_INT_MASK, 32'h0);
      // Sleep silences strobe, word and validity.
      @(posedge conv_clk);
      @(posedge pclk);
      power_state_select <= `PSC_PSS_SLEEP;
      repeat (2) @(negedge conv_clk);
      acc = 3'h0;
      repeat (40) begin
         @(posedge pclk);
         acc = acc | {sample_strobe, word_valid, |sample_word_bits};
      end
      chk(32'(acc), 32'h0);
      rdchk(`PSC_OFF_STATUS, 32'h3, 32'h1);
      @(posedge pclk);
      power_state_select <= 2'h2 | 2'($random(seed) & 1);
      repeat (8) @(posedge pclk);
      rdchk(`PSC_OFF_STATUS, 32'h3, 32'h2);
      // Normal level on the pin, then a software power-down request and a software sleep request.
      // pin held low
      @(posedge pclk);
      power_state_select <= `PSC_PSS_ON;
      apb(1'b1, `PSC_OFF_CTRL, 32'h2);
      rdchk(`PSC_OFF_STATUS, 32'h3, 32'h2);
      apb(1'b1, `PSC_OFF_CTRL, 32'h1);
      rdchk(`PSC_OFF_STATUS, 32'h3, 32'h1);
      apb(1'b1, `PSC_OFF_CTRL, 32'h0);
      rdchk(`PSC_OFF_INT_STAT, 32'h2, 32'h2);
      // Conversion resumes once the pipeline has refilled.
      repeat (10) @(negedge conv_clk);
      chk(32'(word_valid), 32'h1);
      chk_en = 1'b1;
      n0 = cap_cnt;
      repeat (10) @(negedge conv_clk);
      chk(32'(cap_cnt - n0 > 8), 32'h1);
      // The word register is read just after a strobe rise, well clear of the next fall.
      @(posedge sample_strobe);
      v = hist[hist.size() - 8];
      rdchk(`PSC_OFF_LAST_WORD, 32'h1FFF,
         {19'h0, 1'(v > 2047 || v < -2048), enc(v, clock_and_format_select[0])});
      stop_test();
   end
endmodule // tb_pipelined_adc_sample_output

//--- verilog/psc_map.svh
// Register offsets, field positions, reset values and counts for the sample output block.
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH

// ---------------------------------------------------------------------------
// Data path sizes
// ---------------------------------------------------------------------------
`define PSC_WORD_W 12
`define PSC_ANALOG_W 14
`define PSC_LATENCY 7

// ---------------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------------
`define PSC_OFF_CTRL 12'h000
`define PSC_OFF_STATUS 12'h004
`define PSC_OFF_INT_STAT 12'h008
`define PSC_OFF_INT_MASK 12'h00C
`define PSC_OFF_LAST_WORD 12'h010

// ---------------------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------------------
`define PSC_CTRL_SLEEP_BIT 0
`define PSC_CTRL_PDOWN_BIT 1
`define PSC_INT_OVR_BIT 0
`define PSC_INT_PWR_BIT 1
`define PSC_INT_FILL_BIT 2
`define PSC_CTRL_RST 2'h0
`define PSC_INT_RST 3'h0

// ---------------------------------------------------------------------------
// Pin level codes
// ---------------------------------------------------------------------------
`define PSC_PSS_ON 2'h0
`define PSC_PSS_SLEEP 2'h1
`define PSC_CFS_GND 2'h0
`define PSC_CFS_THIRD 2'h1
`define PSC_CFS_TWO_THIRD 2'h2
`define PSC_CFS_SUPPLY 2'h3

`endif

//--- verilog/psc_pipe.sv
// Conversion pipeline: a shift chain of words with a freshness bit per stage.
`timescale 1ns/1ps

module psc_pipe #(
   parameter int W = 13,
   parameter int DEPTH = 7
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Control.
   input wire logic shift,
   input wire logic flush,
   // Data.
   input wire logic [W-1:0] din,
   output logic [W-1:0] head,
   output logic [W-1:0] tail,
   output logic tail_valid
);

   logic [W-1:0] data_q [DEPTH];
   logic [DEPTH-1:0] valid_q;

   // Words advance one stage per shift; flushing only marks them stale,
   // because the held charge is lost but the storage itself remains.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            data_q[i] <= '0;
         end
      end else if (shift) begin
         data_q[0] <= din;
         for (int i = 1; i < DEPTH; i++) begin
            data_q[i] <= data_q[i-1];
         end
      end
   end

   // Freshness bits are cleared by a flush and refill one per shift.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         valid_q <= '0;
      end else if (flush) begin
         valid_q <= '0;
      end else if (shift) begin
         valid_q <= {valid_q[DEPTH-2:0], 1'b1};
      end
   end

   assign head = data_q[0];
   assign tail = data_q[DEPTH-1];
   assign tail_valid = valid_q[DEPTH-1];

endmodule // psc_pipe

//--- verilog/psc_pkg.sv
// Types shared by the sample output block.
package psc_pkg;

   // Power state of the converter.
   typedef enum logic [1:0] {
      PSC_PWR_ON,
      PSC_PWR_SLEEP,
      PSC_PWR_DOWN
   } psc_pwr_e;

   // Width of an APB address.
   typedef logic [11:0] psc_addr_t;

endpackage

//--- verilog/psc_sync3.sv
// Three-stage input synchroniser that passes a change once stages two and three agree.
`timescale 1ns/1ps

module psc_sync3 #(
   parameter int W = 1
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Asynchronous input and synchronised output.
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // The first stage feeds only the second; nothing else looks at it.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // A new value is accepted only when it has stood for two samples.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dout <= '0;
      end else if (s2_q == s3_q) begin
         dout <= s3_q;
      end
   end

endmodule // psc_sync3

//--- verilog/psc_top.sv
// Pipelined sample converter output logic with an APB control and status port.
// Functional notes
// [R1] Each falling edge of the conversion clock holds the tracked input as one sample.
// [R2] A sample appears on the outputs seven conversion clock cycles after it is held.
// [R3] The sample word changes on the falling edge of the sample strobe.
// [R4] The capture logic latches the word on the rising edge of the sample strobe.
// [R5] The sample strobe follows the conversion clock, one period per clock period.
// [R6] Each sample leaves as a twelve-bit parallel word.
// [R7] The conversion clock supplier keeps the rate between 5 and 170 MSPS.
// [R8] The clock-and-format select pin picks clock mode and output coding.
// [R9] Supply: diff/two's; two-thirds: diff/binary; one-third: single/two's; ground: single/binary.
// [R10] Offset binary runs from all zeros to all ones; two's complement inverts its top bit.
// [R11] A high power state pin powers everything down except the reference.
// [R12] A mid-level power state pin selects sleep.
// [R13] The controlling party holds the power state pin low for normal conversion.
// [R14] In sleep or power-down the outputs are undefined and the pipeline contents are lost.
// [R15] The range-exceeded flag is high for an out-of-range sample, aligned with its word.
// [R16] While the conversion clock is high the input is tracked for the next sample.
// [R17] After wake-up the capture logic drops words until the pipeline holds fresh samples.
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
`include "psc_map.svh"

module psc_top (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire psc_pkg::psc_addr_t paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Converter pins in.
   input wire logic conv_clk,
   input wire logic signed [`PSC_ANALOG_W-1:0] analog_level,
   input wire logic [1:0] clock_and_format_select,
   input wire logic [1:0] power_state_select,
   // Converter pins out.
   output logic [`PSC_WORD_W-1:0] sample_word_bits,
   output logic range_exceeded_flag,
   output logic sample_strobe,
   output logic diff_clock_mode,
   output logic word_valid,
   // Interrupt.
   output logic irq
);
   import psc_pkg::*;

   localparam int WW = `PSC_WORD_W;
   localparam int AW = `PSC_ANALOG_W;
   localparam logic signed [AW-1:0] FS_POS = AW'(2047);
   localparam logic signed [AW-1:0] FS_NEG = -AW'(2048);

   // ------------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------------
   logic conv_s;
   logic signed [AW-1:0] analog_s;
   logic [1:0] cfs_s;
   logic [1:0] pss_s;
   logic [AW+3:0] pins_s;

   // The conversion clock gets its own chain so its edges are not held up
   // waiting for the wide input bus to settle.
   psc_sync3 #(.W(1)) u_sync_clk (
      .clk(pclk),
      .rst_n(presetn),
      .din(conv_clk),
      .dout(conv_s)
   );

   psc_sync3 #(.W(AW + 4)) u_sync_pins (
      .clk(pclk),
      .rst_n(presetn),
      .din({analog_level, clock_and_format_select, power_state_select}),
      .dout(pins_s)
   );

   assign analog_s = pins_s[AW+3:4];
   assign cfs_s = pins_s[3:2];
   assign pss_s = pins_s[1:0];

   // ------------------------------------------------------------------
   // Conversion clock edges
   // ------------------------------------------------------------------
   logic conv_prev_q;
   logic conv_fall;
   logic conv_rise;

   // Edge detection on the synchronised level.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_prev_q <= 1'b0;
      end else begin
         conv_prev_q <= conv_s;
      end
   end

   assign conv_fall = conv_prev_q & ~conv_s;
   assign conv_rise = ~conv_prev_q & conv_s;

   // ------------------------------------------------------------------
   // Registers and power state
   // ------------------------------------------------------------------
   logic [1:0] ctrl_q;
   logic [2:0] int_stat_q;
   logic [2:0] int_mask_q;
   logic [2:0] int_evt;
   psc_pwr_e pwr_q;
   psc_pwr_e pwr_d;
   logic run;
   logic wr_en;
   logic addr_ok;

   // Power-down wins over sleep; software requests add to the pin.
   always_comb begin
      pwr_d = PSC_PWR_ON;
      unique case (pss_s)
         `PSC_PSS_ON: pwr_d = PSC_PWR_ON;
         `PSC_PSS_SLEEP: pwr_d = PSC_PWR_SLEEP;
         default: pwr_d = PSC_PWR_DOWN;
      endcase
      if (ctrl_q[`PSC_CTRL_PDOWN_BIT]) begin
         pwr_d = PSC_PWR_DOWN;
      end else if (ctrl_q[`PSC_CTRL_SLEEP_BIT] && pwr_d == PSC_PWR_ON) begin
         pwr_d = PSC_PWR_SLEEP;
      end
   end

   // [R11] [R12] power state select
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_q <= PSC_PWR_ON;
      end else begin
         pwr_q <= pwr_d;
      end
   end

   assign run = (pwr_q == PSC_PWR_ON);

   // ------------------------------------------------------------------
   // Clock mode and output coding
   // ------------------------------------------------------------------
   logic twos_q;

   // [R8] [R9] select pin decode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         diff_clock_mode <= 1'b0;
         twos_q <= 1'b0;
      end else begin
         diff_clock_mode <= (cfs_s == `PSC_CFS_SUPPLY) || (cfs_s == `PSC_CFS_TWO_THIRD);
         twos_q <= (cfs_s == `PSC_CFS_SUPPLY) || (cfs_s == `PSC_CFS_THIRD);
      end
   end

   // ------------------------------------------------------------------
   // Track and hold, quantise
   // ------------------------------------------------------------------
   logic signed [AW-1:0] track_q;
   logic signed [AW-1:0] clipped;
   logic over;
   logic [WW-1:0] ob_code;
   logic [WW:0] head;
   logic [WW:0] tail;
   logic tail_valid;

   // [R16] track while clock high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         track_q <= '0;
      end else if (conv_s) begin
         track_q <= analog_s;
      end
   end

   // [R15] range detect and clip
   always_comb begin
      over = 1'b0;
      clipped = track_q;
      if (track_q > FS_POS) begin
         over = 1'b1;
         clipped = FS_POS;
      end else if (track_q < FS_NEG) begin
         over = 1'b1;
         clipped = FS_NEG;
      end
   end

   // [R10] offset binary from the signed level
   assign ob_code = {~clipped[WW-1], clipped[WW-2:0]};

   // [R1] [R2] hold on falling edge into seven-stage pipe
   psc_pipe #(.W(WW + 1), .DEPTH(`PSC_LATENCY)) u_pipe (
      .clk(pclk),
      .rst_n(presetn),
      .shift(conv_fall & run),
      .flush(~run),
      .din({over, ob_code}),
      .head(head),
      .tail(tail),
      .tail_valid(tail_valid)
   );

   // ------------------------------------------------------------------
   // Output stage
   // ------------------------------------------------------------------

   // [R3] [R6] [R10] [R14] word updates with the strobe's fall
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sample_word_bits <= '0;
         range_exceeded_flag <= 1'b0;
         word_valid <= 1'b0;
      end else if (!run) begin
         sample_word_bits <= '0;
         range_exceeded_flag <= 1'b0;
         word_valid <= 1'b0;
      end else if (conv_fall) begin
         sample_word_bits <= {tail[WW-1] ^ twos_q, tail[WW-2:0]};
         range_exceeded_flag <= tail[WW];
         word_valid <= tail_valid;
      end
   end

   // [R5] strobe follows the clock; held low when not running.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sample_strobe <= 1'b0;
      end else begin
         sample_strobe <= run & conv_s;
      end
   end

   // ------------------------------------------------------------------
   // Interrupts
   // ------------------------------------------------------------------
   assign int_evt[`PSC_INT_OVR_BIT] = conv_fall & run & tail[WW] & tail_valid;
   assign int_evt[`PSC_INT_PWR_BIT] = (pwr_d != pwr_q);
   assign int_evt[`PSC_INT_FILL_BIT] = conv_fall & run & tail_valid & ~word_valid;

   // Write-one-to-clear, but a new event in the same cycle stays set.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_stat_q <= `PSC_INT_RST;
      end else begin
         int_stat_q <= (int_stat_q & ~((wr_en && paddr == `PSC_OFF_INT_STAT && pstrb[0])
                        ? pwdata[2:0] : 3'h0)) | int_evt;
      end
   end

   // Registered so the line never glitches between status updates.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(int_stat_q & int_mask_q);
      end
   end

   // ------------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------------
   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite;
   assign addr_ok = (paddr == `PSC_OFF_CTRL) || (paddr == `PSC_OFF_STATUS)
                    || (paddr == `PSC_OFF_INT_STAT) || (paddr == `PSC_OFF_INT_MASK)
                    || (paddr == `PSC_OFF_LAST_WORD);
   assign pslverr = psel & penable & ~addr_ok;

   // Writable control and mask; all fields sit in byte lane 0.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `PSC_CTRL_RST;
         int_mask_q <= `PSC_INT_RST;
      end else if (wr_en && pstrb[0]) begin
         if (paddr == `PSC_OFF_CTRL) begin
            ctrl_q <= pwdata[1:0];
         end
         if (paddr == `PSC_OFF_INT_MASK) begin
            int_mask_q <= pwdata[2:0];
         end
      end
   end

   // Read mux; unmapped addresses return zero with an error.
   always_comb begin
      prdata = 32'h0000_0000;
      if (psel && !pwrite) begin
         unique case (paddr)
            `PSC_OFF_CTRL: prdata = {30'h0, ctrl_q};
            `PSC_OFF_STATUS: prdata = {26'h0, range_exceeded_flag, word_valid, twos_q,
                                       diff_clock_mode, pwr_q};
            `PSC_OFF_INT_STAT: prdata = {29'h0, int_stat_q};
            `PSC_OFF_INT_MASK: prdata = {29'h0, int_mask_q};
            `PSC_OFF_LAST_WORD: prdata = {19'h0, range_exceeded_flag, sample_word_bits};
            default: prdata = 32'h0000_0000;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   a_hold_sample: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
      conv_fall && run |=> head[WW-1:0] == {~$past(clipped[WW-1]), $past(clipped[WW-2:0])})
      else $error("held sample differs from tracked input");

   a_pipe_latency: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
      conv_fall && run && tail_valid |=> word_valid && range_exceeded_flag == $past(tail[WW]))
      else $error("pipeline tail not delivered on the clock fall");

   a_word_on_fall: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
      run && $past(run) && $changed(sample_word_bits) |-> $fell(sample_strobe))
      else $error("sample word changed away from a strobe fall");

   a_strobe_rise: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
      run && conv_rise |=> sample_strobe ##1 ($stable(sample_strobe) || !conv_s))
      else $error("strobe did not follow the conversion clock");

   a_format_code: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
      cfs_s == `PSC_CFS_THIRD |=> !diff_clock_mode && twos_q)
      else $error("one-third select level decoded wrongly");

   a_twos_invert: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
      conv_fall && run |=> sample_word_bits[WW-1] == ($past(tail[WW-1]) ^ $past(twos_q)))
      else $error("output coding top bit wrong");

   a_pdown_quiet: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
      pwr_q == PSC_PWR_DOWN |=> !sample_strobe && sample_word_bits == '0)
      else $error("outputs active in power-down");

   a_sleep_flush: assert property (@(posedge pclk) disable iff (!presetn) // [R12] [R14]
      pwr_q == PSC_PWR_SLEEP ##1 run |-> !word_valid ##1 !word_valid)
      else $error("stale word marked valid after sleep");

   a_range_flag: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
      conv_fall && run && (track_q > FS_POS) |=> head[WW])
      else $error("out-of-range sample not flagged");

   a_track_high: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
      conv_s |=> track_q == $past(analog_s))
      else $error("input not tracked while clock high");

endmodule // psc_top
